// *** core/dct_counter_timer.v ***
// Dual down-counting timer pair with transmit and demodulation modes
//
// What this block does
// - Timer registers live in expanded bank D
// - High-level narrow capture at offset 0BH
// - Low-level narrow capture at offset 0AH
// - Wide capture upper byte 09H, lower 08H
// - Writes to capture registers change nothing
// - Writable wide upper hold at offset 07H
// - Transmit: field picks AND/OR/NOR/NAND combine
// - Demodulation: same field picks detected edges
// - Submode: normal, alternate, force low, high
// - Demodulation: submode sets glitch filter width
// - Edge detector pulses positive or negative line
// - Narrow output starts at init, else complement
// - Wide output same, only normal or alternating
// - Rising-edge flag set, cleared by one
// - Falling-edge flag set, cleared by one
// - Narrow wrap to FFh is no timeout
// - Stop and flag clear act one cycle later
// - Demodulation counting starts at first edge
// - Later edges capture complemented count, narrow by polarity
`timescale 1ns/100ps
`default_nettype none
`include "dct_defs.vh"

module dct_counter_timer (
  // Clock, reset, enable
  input wire clk,
  input wire rst,
  input wire ce,
  // Register access from the core
  input wire [3:0] regBank,
  input wire [3:0] regAddr,
  input wire regWr,
  input wire regRd,
  input wire [7:0] regWrData,
  output reg [7:0] regRdData,
  // Capture input pins
  input wire captureInputPinA,
  input wire captureInputPinB,
  // Timer outputs
  output reg narrowTimerOutput,
  output reg wideTimerOutput,
  output reg combinedOutput,
  // Edge detector pulses
  output reg posEdgePulse,
  output reg negEdgePulse
);

  // --------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------
  function [4:0] glitchLimit;
    input [1:0] code;
    case (code)
      2'h0: glitchLimit = `DCT_GLITCH_W0;
      2'h1: glitchLimit = `DCT_GLITCH_W1;
      2'h2: glitchLimit = `DCT_GLITCH_W2;
      default: glitchLimit = `DCT_GLITCH_W3;
    endcase
  endfunction

  function combine;
    input [1:0] code;
    input a;
    input b;
    case (code)
      `DCT_LOG_AND: combine = a & b;
      `DCT_LOG_OR: combine = a | b;
      `DCT_LOG_NOR: combine = ~(a | b);
      default: combine = ~(a & b);
    endcase
  endfunction

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  reg [7:0] ctrl0_q, ctrl1_q, ctrl2_q;
  reg [2:0] ctrl3_q;
  reg [7:0] narrowRelH_q, narrowRelL_q, wideRelL_q, wideHold_q;
  reg [7:0] wideCapL_q, wideCapH_q, narrowCapL_q, narrowCapH_q;
  reg riseFlag_q, fallFlag_q;
  reg stopNarrowPend_q, stopWidePend_q, clrRisePend_q, clrFallPend_q;
  reg pinA1_q, pinA2_q, pinB1_q, pinB2_q;
  reg filtLvl_q, prevLvl_q;
  reg [4:0] glitchCnt_q;
  reg narrowRun_q, narrowStarted_q, narrowArmed_q;
  reg wideRun_q, wideStarted_q, wideArmed_q;
  reg [7:0] narrowCnt_q;
  reg [15:0] wideCnt_q;
  reg narrowLvl_q, wideLvl_q;

  wire bankHit = (regBank == `DCT_BANK_D);
  wire wrHit = ce & regWr & bankHit;
  wire demod = ctrl1_q[`DCT_C1_DEMOD];
  wire [1:0] logicSel = ctrl1_q[`DCT_C1_LOGIC_HI:`DCT_C1_LOGIC_LO];
  wire [1:0] subSel = ctrl1_q[`DCT_C1_SUB_HI:`DCT_C1_SUB_LO];
  wire pingPong = ~demod & (subSel == `DCT_SUB_ALT);
  wire syncIn = ctrl1_q[`DCT_C1_PINSEL] ? pinB2_q : pinA2_q;
  wire posEdge = filtLvl_q & ~prevLvl_q;
  wire negEdge = ~filtLvl_q & prevLvl_q;
  wire risePick = posEdge & logicSel[0];
  wire fallPick = negEdge & logicSel[1];
  wire edgeHit = risePick | fallPick;
  wire [15:0] wideReload = {wideHold_q, wideRelL_q};

  // --------------------------------------------------------------------
  // Input synchroniser, glitch filter, edge detector
  // --------------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pinA1_q <= 1'b0;
      pinA2_q <= 1'b0;
      pinB1_q <= 1'b0;
      pinB2_q <= 1'b0;
      filtLvl_q <= 1'b0;
      prevLvl_q <= 1'b0;
      glitchCnt_q <= 5'h00;
      posEdgePulse <= 1'b0;
      negEdgePulse <= 1'b0;
    end else if (ce) begin
      pinA1_q <= captureInputPinA;
      pinA2_q <= pinA1_q;
      pinB1_q <= captureInputPinB;
      pinB2_q <= pinB1_q;
      prevLvl_q <= filtLvl_q;
      posEdgePulse <= demod & risePick;
      negEdgePulse <= demod & fallPick;
      // Level must hold for the full width before it is believed
      if (syncIn == filtLvl_q) begin
        glitchCnt_q <= 5'h00;
      end else if (glitchCnt_q + 5'h01 >= glitchLimit(subSel)) begin
        filtLvl_q <= syncIn;
        glitchCnt_q <= 5'h00;
      end else begin
        glitchCnt_q <= glitchCnt_q + 5'h01;
      end
    end
  end

  // --------------------------------------------------------------------
  // Register writes, flags and deferred stop/clear
  // --------------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl0_q <= `DCT_CTRL_RST;
      ctrl1_q <= `DCT_CTRL_RST;
      ctrl2_q <= `DCT_CTRL_RST;
      ctrl3_q <= 3'h0;
      narrowRelH_q <= `DCT_RELOAD_RST;
      narrowRelL_q <= `DCT_RELOAD_RST;
      wideRelL_q <= `DCT_RELOAD_RST;
      wideHold_q <= `DCT_RELOAD_RST;
      riseFlag_q <= 1'b0;
      fallFlag_q <= 1'b0;
      stopNarrowPend_q <= 1'b0;
      stopWidePend_q <= 1'b0;
      clrRisePend_q <= 1'b0;
      clrFallPend_q <= 1'b0;
    end else if (ce) begin
      stopNarrowPend_q <= 1'b0;
      stopWidePend_q <= 1'b0;
      clrRisePend_q <= 1'b0;
      clrFallPend_q <= 1'b0;
      // A set in the same cycle as the clear wins
      if (clrRisePend_q) riseFlag_q <= 1'b0;
      if (clrFallPend_q) fallFlag_q <= 1'b0;
      if (demod & risePick) riseFlag_q <= 1'b1;
      if (demod & fallPick) fallFlag_q <= 1'b1;
      if (wrHit) begin
        case (regAddr)
          `DCT_OFS_CTRL0: begin
            ctrl0_q <= regWrData;
            stopNarrowPend_q <= ~regWrData[`DCT_EN_BIT];
          end
          `DCT_OFS_CTRL1: begin
            ctrl1_q[7:2] <= regWrData[7:2];
            if (demod) begin
              clrRisePend_q <= regWrData[`DCT_C1_INIT8];
              clrFallPend_q <= regWrData[`DCT_C1_INIT16];
            end else begin
              ctrl1_q[1:0] <= regWrData[1:0];
            end
          end
          `DCT_OFS_CTRL2: begin
            ctrl2_q <= regWrData;
            stopWidePend_q <= ~regWrData[`DCT_EN_BIT];
          end
          `DCT_OFS_CTRL3: ctrl3_q <= regWrData[7:5];
          `DCT_OFS_NRELH: narrowRelH_q <= regWrData;
          `DCT_OFS_NRELL: narrowRelL_q <= regWrData;
          `DCT_OFS_WRELL: wideRelL_q <= regWrData;
          `DCT_OFS_WHOLD: wideHold_q <= regWrData;
          default: ;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Timers
  // --------------------------------------------------------------------
  // Enable bits start a timer at once; their clearing acts a cycle later
  // so a status clear in the same write never races the stop.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      narrowRun_q <= 1'b0;
      narrowStarted_q <= 1'b0;
      narrowArmed_q <= 1'b0;
      wideRun_q <= 1'b0;
      wideStarted_q <= 1'b0;
      wideArmed_q <= 1'b0;
      narrowCnt_q <= 8'h00;
      wideCnt_q <= 16'h0000;
      narrowLvl_q <= 1'b0;
      wideLvl_q <= 1'b0;
      narrowCapL_q <= `DCT_CAP_RST;
      narrowCapH_q <= `DCT_CAP_RST;
      wideCapL_q <= `DCT_CAP_RST;
      wideCapH_q <= `DCT_CAP_RST;
    end else if (ce) begin
      if (wrHit && regAddr == `DCT_OFS_CTRL0 && regWrData[`DCT_EN_BIT]) begin
        narrowRun_q <= 1'b1;
      end
      if (wrHit && regAddr == `DCT_OFS_CTRL2 && regWrData[`DCT_EN_BIT]) begin
        wideRun_q <= 1'b1;
      end
      // Narrow timer
      if (stopNarrowPend_q) begin
        narrowRun_q <= 1'b0;
        narrowStarted_q <= 1'b0;
        narrowArmed_q <= 1'b0;
      end else if (narrowRun_q & demod) begin
        if (!narrowArmed_q) begin
          if (edgeHit) begin
            narrowArmed_q <= 1'b1;
            narrowCnt_q <= narrowRelH_q;
          end
        end else if (edgeHit) begin
          if (fallPick) begin
            narrowCapH_q <= ~narrowCnt_q;
          end else begin
            narrowCapL_q <= ~narrowCnt_q;
          end
          narrowCnt_q <= narrowRelH_q;
        end else begin
          // Plain wrap, never a timeout
          narrowCnt_q <= narrowCnt_q - 8'h01;
        end
      end else if (narrowRun_q) begin
        if (!narrowStarted_q) begin
          narrowStarted_q <= 1'b1;
          narrowLvl_q <= ctrl1_q[`DCT_C1_INIT8];
          narrowCnt_q <= ctrl1_q[`DCT_C1_INIT8] ? narrowRelH_q : narrowRelL_q;
        end else if (narrowCnt_q == 8'h00) begin
          narrowLvl_q <= ~narrowLvl_q;
          narrowCnt_q <= narrowLvl_q ? narrowRelL_q : narrowRelH_q;
          if (pingPong) begin
            narrowRun_q <= 1'b0;
            narrowStarted_q <= 1'b0;
            wideRun_q <= 1'b1;
            wideStarted_q <= 1'b0;
          end else if (ctrl0_q[`DCT_SINGLE_BIT]) begin
            narrowRun_q <= 1'b0;
            narrowStarted_q <= 1'b0;
          end
        end else begin
          narrowCnt_q <= narrowCnt_q - 8'h01;
        end
      end else begin
        narrowLvl_q <= ~ctrl1_q[`DCT_C1_INIT8];
        narrowStarted_q <= 1'b0;
        narrowArmed_q <= 1'b0;
      end
      // Wide timer
      if (stopWidePend_q) begin
        wideRun_q <= 1'b0;
        wideStarted_q <= 1'b0;
        wideArmed_q <= 1'b0;
      end else if (wideRun_q & demod) begin
        if (!wideArmed_q) begin
          if (edgeHit) begin
            wideArmed_q <= 1'b1;
            wideCnt_q <= wideReload;
          end
        end else if (edgeHit) begin
          wideCapH_q <= ~wideCnt_q[15:8];
          wideCapL_q <= ~wideCnt_q[7:0];
          wideCnt_q <= wideReload;
        end else begin
          wideCnt_q <= wideCnt_q - 16'h0001;
        end
      end else if (wideRun_q) begin
        if (!wideStarted_q) begin
          wideStarted_q <= 1'b1;
          wideLvl_q <= ctrl1_q[`DCT_C1_INIT16];
          wideCnt_q <= wideReload;
        end else if (wideCnt_q == 16'h0000) begin
          wideLvl_q <= ~wideLvl_q;
          wideCnt_q <= wideReload;
          if (pingPong) begin
            wideRun_q <= 1'b0;
            wideStarted_q <= 1'b0;
            narrowRun_q <= 1'b1;
            narrowStarted_q <= 1'b0;
          end else if (ctrl2_q[`DCT_SINGLE_BIT]) begin
            wideRun_q <= 1'b0;
            wideStarted_q <= 1'b0;
          end
        end else begin
          wideCnt_q <= wideCnt_q - 16'h0001;
        end
      end else begin
        wideLvl_q <= ~ctrl1_q[`DCT_C1_INIT16];
        wideStarted_q <= 1'b0;
        wideArmed_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Outputs and read data
  // --------------------------------------------------------------------
  // Force codes act in transmit only and override the wide timer level only
  wire forceLow = ~demod & (subSel == `DCT_SUB_FORCE0);
  wire forceHigh = ~demod & (subSel == `DCT_SUB_FORCE1);
  wire wideOutNext = (wideLvl_q | forceHigh) & ~forceLow;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      narrowTimerOutput <= 1'b0;
      wideTimerOutput <= 1'b0;
      combinedOutput <= 1'b0;
      regRdData <= 8'h00;
    end else if (ce) begin
      narrowTimerOutput <= narrowLvl_q;
      wideTimerOutput <= wideOutNext;
      combinedOutput <= combine(logicSel, narrowLvl_q, wideOutNext);
      if (regRd & bankHit) begin
        case (regAddr)
          `DCT_OFS_CTRL0: regRdData <= ctrl0_q;
          `DCT_OFS_CTRL1: regRdData <= demod ?
              {ctrl1_q[7:2], riseFlag_q, fallFlag_q} : ctrl1_q;
          `DCT_OFS_CTRL2: regRdData <= ctrl2_q;
          `DCT_OFS_CTRL3: regRdData <= {ctrl3_q, `DCT_C3_LOW_ONES};
          `DCT_OFS_NRELH: regRdData <= narrowRelH_q;
          `DCT_OFS_NRELL: regRdData <= narrowRelL_q;
          `DCT_OFS_WRELL: regRdData <= wideRelL_q;
          `DCT_OFS_WHOLD: regRdData <= wideHold_q;
          `DCT_OFS_WCAPL: regRdData <= wideCapL_q;
          `DCT_OFS_WCAPH: regRdData <= wideCapH_q;
          `DCT_OFS_NCAPL: regRdData <= narrowCapL_q;
          `DCT_OFS_NCAPH: regRdData <= narrowCapH_q;
          default: regRdData <= 8'h00;
        endcase
      end
    end
  end

endmodule // dct_counter_timer
`default_nettype wire

// *** core/dct_defs.vh ***
// Register offsets, field positions, codes and reset values of the timer pair
`ifndef DCT_DEFS_VH
`define DCT_DEFS_VH

// ----------------------------------------------------------------------
// Bank select and offsets inside the expanded bank
// ----------------------------------------------------------------------
`define DCT_BANK_D 4'hd
`define DCT_OFS_CTRL0 4'h0
`define DCT_OFS_CTRL1 4'h1
`define DCT_OFS_CTRL2 4'h2
`define DCT_OFS_CTRL3 4'h3
`define DCT_OFS_NRELH 4'h4
`define DCT_OFS_NRELL 4'h5
`define DCT_OFS_WRELL 4'h6
`define DCT_OFS_WHOLD 4'h7
`define DCT_OFS_WCAPL 4'h8
`define DCT_OFS_WCAPH 4'h9
`define DCT_OFS_NCAPL 4'ha
`define DCT_OFS_NCAPH 4'hb

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define DCT_EN_BIT 7
`define DCT_SINGLE_BIT 6
`define DCT_C1_PINSEL 7
`define DCT_C1_DEMOD 6
`define DCT_C1_LOGIC_HI 5
`define DCT_C1_LOGIC_LO 4
`define DCT_C1_SUB_HI 3
`define DCT_C1_SUB_LO 2
`define DCT_C1_INIT8 1
`define DCT_C1_INIT16 0

// ----------------------------------------------------------------------
// Codes
// ----------------------------------------------------------------------
`define DCT_LOG_AND 2'h0
`define DCT_LOG_OR 2'h1
`define DCT_LOG_NOR 2'h2
`define DCT_LOG_NAND 2'h3
`define DCT_SUB_NORMAL 2'h0
`define DCT_SUB_ALT 2'h1
`define DCT_SUB_FORCE0 2'h2
`define DCT_SUB_FORCE1 2'h3

// ----------------------------------------------------------------------
// Glitch widths in clock cycles, reset values
// ----------------------------------------------------------------------
`define DCT_GLITCH_W0 5'h01
`define DCT_GLITCH_W1 5'h04
`define DCT_GLITCH_W2 5'h08
`define DCT_GLITCH_W3 5'h10
`define DCT_CTRL_RST 8'h00
`define DCT_RELOAD_RST 8'h00
`define DCT_CAP_RST 8'h00
`define DCT_C3_LOW_ONES 5'h1f

`endif

// *** dv/dct_counter_timer_chk.sv ***
// Port-level assertions for the timer pair
`timescale 1ns/100ps
`default_nettype none
module dct_counter_timer_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Register access
  input wire logic [3:0] regBank,
  input wire logic [3:0] regAddr,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  // Pins and outputs
  input wire logic captureInputPinA,
  input wire logic captureInputPinB,
  input wire logic narrowTimerOutput,
  input wire logic wideTimerOutput,
  input wire logic combinedOutput,
  input wire logic posEdgePulse,
  input wire logic negEdgePulse
);
  // ----
  // Shadow of control one, mode bits only used
  // ----
  logic [7:0] ctl1Q;
  always @(posedge clk or posedge rst) begin
    if (rst)
      ctl1Q <= 8'h00;
    else if (ce && regWr && regBank == 4'hd && regAddr == 4'h1)
      ctl1Q <= regWrData;
  end
  function automatic logic mix(input logic [1:0] c, input logic a,
                               input logic b);
    case (c)
      2'h0: mix = a & b;
      2'h1: mix = a | b;
      2'h2: mix = ~(a | b);
      default: mix = ~(a & b);
    endcase
  endfunction
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence wrHold;
    ce && regWr && regBank == 4'hd && regAddr == 4'h7;
  endsequence
  sequence rdHold;
    ce && regRd && regBank == 4'hd && regAddr == 4'h7;
  endsequence
  // Outputs settled long enough for the registered combine to follow
  sequence quiet;
    ($stable(narrowTimerOutput) && $stable(wideTimerOutput) &&
     $stable(ctl1Q) && !ctl1Q[6])[*3];
  endsequence
  a_hold_readback: assert property (wrHold ##2 rdHold |=>
    regRdData == $past(regWrData, 3)) else $error("hold readback differs");
  a_other_bank: assert property (regRd && regBank != 4'hd |=>
    $stable(regRdData)) else $error("foreign bank read answered");
  a_reserved_ones: assert property (ce && regRd && regBank == 4'hd &&
    regAddr == 4'h3 |=> regRdData[4:0] == 5'h1f)
    else $error("reserved bits not ones");
  a_force_low: assert property ((!ctl1Q[6] && ctl1Q[3:2] == 2'h2)[*3]
    |-> !wideTimerOutput) else $error("wide output not forced low");
  a_force_high: assert property ((!ctl1Q[6] && ctl1Q[3:2] == 2'h3)[*3]
    |-> wideTimerOutput) else $error("wide output not forced high");
  a_combine_logic: assert property (quiet |-> combinedOutput ==
    mix(ctl1Q[5:4], narrowTimerOutput, wideTimerOutput))
    else $error("combined output wrong");
  // Pulse was decided on the previous edge, so look at the mode then
  a_rise_select: assert property (posEdgePulse |->
    $past(ctl1Q[6]) && $past(ctl1Q[4]))
    else $error("rising pulse not selected");
  a_fall_select: assert property (negEdgePulse |->
    $past(ctl1Q[6]) && $past(ctl1Q[5]))
    else $error("falling pulse not selected");
  a_pulse_single: assert property (posEdgePulse |=> !posEdgePulse)
    else $error("rising edge pulse too long");
  a_fall_single: assert property (negEdgePulse |=> !negEdgePulse)
    else $error("falling edge pulse too long");
endmodule // dct_counter_timer_chk
bind dct_counter_timer dct_counter_timer_chk chk (.clk, .rst, .ce,
  .regBank, .regAddr, .regWr, .regRd, .regWrData, .regRdData,
  .captureInputPinA, .captureInputPinB, .narrowTimerOutput,
  .wideTimerOutput, .combinedOutput, .posEdgePulse, .negEdgePulse);
`default_nettype wire

// *** dv/dct_counter_timer_tb.sv ***
// Self-checking bench for the timer pair
`timescale 1ns/100ps
`default_nettype none
module dct_counter_timer_tb;
  logic clk, rst, ce, regWr, regRd, start, pinSel;
  logic [3:0] regBank, regAddr;
  logic [7:0] regWrData, rdVal, hiLen, loLen;
  wire logic srcPin, nOut, wOut, cOut;
  wire logic [7:0] regRdData;
  int fails, nCompared;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  dct_counter_timer uut (.clk(clk), .rst(rst), .ce(ce), .regBank(regBank),
    .regAddr(regAddr), .regWr(regWr), .regRd(regRd),
    .regWrData(regWrData), .regRdData(regRdData),
    .captureInputPinA(pinSel ? 1'b0 : srcPin),
    .captureInputPinB(pinSel ? srcPin : 1'b0),
    .narrowTimerOutput(nOut), .wideTimerOutput(wOut),
    .combinedOutput(cOut), .posEdgePulse(), .negEdgePulse());
  dct_sig_src src (.clk(clk), .start(start), .hiLen(hiLen),
    .loLen(loLen), .pin(srcPin));
  // ----
  // Bus cycles and comparison
  // ----
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWr = 1'b1;
    @(negedge clk) regWr = 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [3:0] a);
    regAddr = a;
    regRd = 1'b1;
    @(negedge clk) regRd = 1'b0;
    rdVal = regRdData;
    @(negedge clk);
  endtask
  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] got);
    nCompared++;
    if (got !== e) begin
      fails++;
      $display("wrong value %s: expected %h, seen %h", what, e, got);
    end
  endtask
  task automatic print_verdict;
    $display("compared %0d, mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic testRegs;
    int i;
    rd(4'h3);
    chk("ctrl3", 8'h1f, rdVal);
    wr(4'h7, 8'h5a);
    rd(4'h7);
    chk("wide hold", 8'h5a, rdVal);
    ce = 1'b0;
    wr(4'h7, 8'ha5);
    ce = 1'b1;
    rd(4'h7);
    chk("frozen hold", 8'h5a, rdVal);
    regBank = 4'he;
    rd(4'hc);
    regBank = 4'hd;
    chk("other bank", 8'h5a, rdVal);
    for (i = 8; i < 12; i++) begin
      wr(i[3:0], 8'hff);
      rd(i[3:0]);
      chk("capture", 8'h00, rdVal);
    end
    rd(4'hc);
    chk("unmapped", 8'h00, rdVal);
    $display("test registers done");
  endtask
  task automatic testCombine;
    int c, i;
    logic a, b, e;
    for (c = 0; c < 4; c++) begin
      for (i = 0; i < 4; i++) begin
        wr(4'h1, {2'b00, c[1:0], 2'b00, i[1:0]});
        repeat (3) @(negedge clk);
        a = ~i[1];
        b = ~i[0];
        e = c == 0 ? a & b : c == 1 ? a | b : c == 2 ? ~(a | b) : ~(a & b);
        chk("narrow idle", {7'h00, a}, {7'h00, nOut});
        chk("wide idle", {7'h00, b}, {7'h00, wOut});
        chk("combined", {7'h00, e}, {7'h00, cOut});
      end
    end
    wr(4'h1, 8'h08);
    repeat (3) @(negedge clk);
    chk("force low", 8'h00, {7'h00, wOut});
    wr(4'h1, 8'h0d);
    repeat (3) @(negedge clk);
    chk("force high", 8'h01, {7'h00, wOut});
    wr(4'h1, 8'h00);
    $display("test combine done");
  endtask
  task automatic testNarrow;
    int t;
    wr(4'h4, 8'h03);
    wr(4'h5, 8'h03);
    wr(4'h1, 8'h02);
    repeat (2) @(negedge clk);
    chk("narrow off", 8'h00, {7'h00, nOut});
    wr(4'h0, 8'h80);
    @(negedge clk);
    chk("narrow start", 8'h01, {7'h00, nOut});
    t = 0;
    repeat (20) @(negedge clk) if (nOut !== 1'b1) t++;
    // Reload 3 gives four cycles per level
    chk("narrow low cycles", 8'h09, t[7:0]);
    wr(4'h0, 8'h00);
    repeat (2) @(negedge clk);
    chk("narrow stop", 8'h00, {7'h00, nOut});
    $display("test narrow done");
  endtask
  // Each timer holds its level four cycles, then a one-cycle hand-off gap
  task automatic testAlternate;
    int n, w, b;
    wr(4'h2, 8'h40);
    wr(4'h7, 8'h00);
    wr(4'h6, 8'h03);
    wr(4'h1, 8'h17);
    wr(4'h0, 8'hc0);
    n = 0;
    w = 0;
    b = 0;
    repeat (20) @(negedge clk) begin
      n += nOut;
      w += wOut;
      b += cOut;
    end
    chk("narrow high cycles", 8'h08, n[7:0]);
    chk("wide high cycles", 8'h08, w[7:0]);
    chk("or high cycles", 8'h10, b[7:0]);
    wr(4'h1, 8'h13);
    repeat (12) @(negedge clk);
    n = 0;
    repeat (20) @(negedge clk) n += nOut + wOut;
    chk("alternation ended", 8'h00, n[7:0]);
    $display("test alternation done");
  endtask
  // Arguments are interval lengths; a capture holds one cycle less
  task automatic testDemod(input logic sel, input logic [1:0] edg,
    input logic [7:0] eHi, input logic [7:0] eLo, input logic [1:0] eFl);
    int n;
    pinSel = sel;
    wr(4'h4, 8'hff);
    wr(4'h5, 8'hff);
    wr(4'h1, {sel, 1'b1, edg, 4'h3});
    wr(4'h0, 8'h80);
    start = 1'b1;
    @(negedge clk) start = 1'b0;
    for (n = 0; n < 200 && src.phaseQ != 2'h0; n++) @(negedge clk);
    repeat (8) @(negedge clk);
    wr(4'h0, 8'h00);
    rd(4'hb);
    chk("high capture", eHi - 8'h01, rdVal);
    rd(4'ha);
    chk("low capture", eLo - 8'h01, rdVal);
    rd(4'h1);
    chk("edge flags", {6'h00, eFl}, {6'h00, rdVal[1:0]});
    wr(4'h1, {sel, 1'b1, edg, 4'h3});
    rd(4'h1);
    chk("flags cleared", 8'h00, {6'h00, rdVal[1:0]});
    $display("test demodulation done");
  endtask
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regBank = 4'hd;
    regAddr = 4'h0;
    regWrData = 8'h00;
    start = 1'b0;
    pinSel = 1'b0;
    hiLen = 8'h14;
    loLen = 8'h0a;
    fails = 0;
    nCompared = 0;
    repeat (3) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    testRegs;
    testCombine;
    testNarrow;
    testAlternate;
    testDemod(1'b0, 2'b11, 8'h14, 8'h0a, 2'b11);
    testDemod(1'b1, 2'b01, 8'h14, 8'h1e, 2'b10);
    print_verdict;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    print_verdict;
  end
endmodule // dct_counter_timer_tb
`default_nettype wire

// *** dv/dct_sig_src.sv ***
// Far-side modulated input burst source
`timescale 1ns/100ps
`default_nettype none
module dct_sig_src (
  // Clock and control
  input wire logic clk,
  input wire logic start,
  input wire logic [7:0] hiLen,
  input wire logic [7:0] loLen,
  // Modulated pin
  output var logic pin
);
  logic [7:0] cntQ;
  logic [1:0] phaseQ;
  initial begin
    pin = 1'b0;
    cntQ = 8'h00;
    phaseQ = 2'h0;
  end
  // Burst: rise, high, low, high, then back to idle low
  always @(posedge clk) begin
    if (start) begin
      pin <= 1'b1;
      cntQ <= hiLen;
      phaseQ <= 2'h1;
    end else if (phaseQ != 2'h0) begin
      if (cntQ > 8'h01)
        cntQ <= cntQ - 8'h01;
      else begin
        pin <= ~pin;
        cntQ <= pin ? loLen : hiLen;
        phaseQ <= (phaseQ == 2'h3) ? 2'h0 : phaseQ + 2'h1;
      end
    end
  end
endmodule // dct_sig_src
`default_nettype wire
